// *** common/fsc_pkg.sv ***
// Constants shared by the flash security and divider block
package fsc_pkg;

    // ****************************************************************
    // Register offsets
    // ****************************************************************
    localparam logic [3:0] FSC_OFS_DIVIDER = 4'h0;
    localparam logic [3:0] FSC_OFS_OPTION  = 4'h1;
    localparam logic [3:0] FSC_OFS_CONFIG  = 4'h2;
    localparam logic [3:0] FSC_OFS_PROTECT = 4'h3;
    localparam logic [3:0] FSC_OFS_STATUS  = 4'h4;

    // ****************************************************************
    // Field positions and masks
    // ****************************************************************
    localparam int         FSC_DIV_LOADED_BIT = 7;
    localparam int         FSC_DIV_PRESCALE_BIT = 6;
    localparam logic [7:0] FSC_DIV_WR_MASK = 8'h7F;
    localparam int         FSC_OPT_BACKDOOR_KEY_ENABLE_BIT = 7;
    localparam logic [7:0] FSC_OPT_RD_MASK = 8'hC3;
    localparam int         FSC_CFG_KEY_ACCESS_ENABLE_BIT = 5;
    localparam logic [7:0] FSC_CFG_WR_MASK = 8'hE0;
    localparam int         FSC_PROT_DISABLE_BIT = 0;
    localparam logic [1:0] FSC_SEC_UNSECURED = 2'h2;

    // ****************************************************************
    // Reset values and sizes
    // ****************************************************************
    localparam logic [7:0] FSC_DIV_RESET = 8'h00;
    localparam logic [7:0] FSC_CFG_RESET = 8'h00;
    localparam logic [2:0] FSC_PRESCALE_LAST = 3'h7;
    localparam int         FSC_KEY_BYTES = 8;
    localparam logic [15:0] FSC_KEY_BASE = 16'hFFB0;

endpackage : fsc_pkg

// *** common/fsc_key_if.sv ***
// Link between the security gate and the key comparison unit
interface fsc_key_if;
    logic        wrEn;
    logic [2:0]  idx;
    logic [7:0]  data;
    logic        restart;
    logic        check;
    logic [63:0] nvKey;
    logic        match;

    modport gate (output wrEn, idx, data, restart, check, nvKey,
                  input match);
    modport keymod (input wrEn, idx, data, restart, check, nvKey,
                    output match);
endinterface : fsc_key_if

// *** src/fsc_key_cmp.sv ***
// Backdoor key capture store and comparison unit
module fsc_key_cmp
    import fsc_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic resetn,
    fsc_key_if.keymod k
);

    typedef struct packed {
        logic [7:0][7:0] bytes;
        logic [3:0]      count;
        logic            inOrder;
        logic            match;
    } fsc_key_state_t;

    fsc_key_state_t st;
    fsc_key_state_t next_st;

    assign k.match = st.match;

    always_comb begin
        next_st = st;
        next_st.match = 1'b0;
        if (k.restart) begin
            next_st.count = 4'h0;
            next_st.inOrder = 1'b1;
        end else if (k.wrEn) begin
            // Bytes must arrive first to last
            next_st.bytes[k.idx] = k.data;
            if ({1'b0, k.idx} != st.count) begin
                next_st.inOrder = 1'b0;
            end
            if (st.count != 4'(FSC_KEY_BYTES)) begin
                next_st.count = st.count + 4'h1;
            end
        end
        if (k.check) begin
            next_st.match = st.inOrder && (st.count == 4'(FSC_KEY_BYTES))
                            && (st.bytes == k.nvKey);
            next_st.count = 4'h0;
            next_st.inOrder = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            st <= '0;
            st.inOrder <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

endmodule : fsc_key_cmp

// *** src/fsc_security.sv ***
// Flash and RAM security gate with flash clock divider
// Functional notes
// - Secure: block unsecured and debug memory access
// - Secure-fetched code keeps full access
// - Only state 1:0 means unsecured
// - Reset copies nonvolatile option byte
// - Debug module refused while secure
// - Secure: background entry only via pin at reset
// - Key enable clear disables backdoor key
// - Key access on: key writes are captured
// - Matching key on access clear unsecures
// - Key writes only from secure code
// - Protecting vector block protects key
// - Protection register written only by debug
// - Blank flash check disengages security
// - Divider bit 7 read-only, rest write-once
// - Loaded flag gates program and erase
// - Prescale selects bus clock or /8
// - Flash clock is input over divisor+1
// - Timing pulse lasts one bus clock
// - Option register read-only, reset reload
module fsc_security
    import fsc_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    // Register port
    input  wire logic [3:0]  regAddr,
    input  wire logic [7:0]  regWdata,
    input  wire logic        regWr,
    input  wire logic        regRd,
    input  wire logic        regFromDebug,
    output logic [7:0]       regRdata,
    // Nonvolatile contents seen at reset
    input  wire logic [7:0]  optNvByte,
    input  wire logic [7:0]  protNvByte,
    input  wire logic [63:0] nvKey,
    input  wire logic        backgroundModePin,
    // Requests from debug and command logic
    input  wire logic        dbgEnableReq,
    input  wire logic        blankCheckOk,
    // Memory access from CPU or debug
    input  wire logic        memReq,
    input  wire logic        memWr,
    input  wire logic [15:0] memAddr,
    input  wire logic [7:0]  memWdata,
    input  wire logic        memSrcSecure,
    input  wire logic        memSrcDebug,
    input  wire logic        memTargetSecure,
    input  wire logic        memTargetFlash,
    input  wire logic [7:0]  arrayRdata,
    output logic             memWrEn,
    output logic [7:0]       memWrData,
    output logic [7:0]       memRdata,
    output logic             memBlocked,
    output logic             cmdWrite,
    // Security and flash clock status
    output logic             secure,
    output logic             dbgModuleEn,
    output logic             bgEntryOk,
    output logic             keyProtected,
    output logic             progEraseEn,
    output logic             flashPulse
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [7:0] divider;
        logic [7:0] option;
        logic [7:0] cfgReg;
        logic [7:0] protect;
        logic [2:0] preCnt;
        logic [5:0] divCnt;
        logic       bgPinLow;
        logic       firstCycle;
        logic [7:0] regRdata;
        logic       memWrEn;
        logic [7:0] memWrData;
        logic [7:0] memRdata;
        logic       memBlocked;
        logic       cmdWrite;
        logic       secure;
        logic       dbgModuleEn;
        logic       bgEntryOk;
        logic       keyProtected;
        logic       progEraseEn;
        logic       flashPulse;
    } fsc_state_t;

    fsc_state_t st;
    fsc_state_t next_st;
    fsc_key_if  keyLink ();

    // Security decode used in several places
    function automatic logic isSecure(input logic [7:0] opt);
        isSecure = (opt[1:0] != FSC_SEC_UNSECURED);
    endfunction : isSecure

    function automatic logic isKeyAddr(input logic [15:0] a);
        isKeyAddr = (a >= FSC_KEY_BASE) &&
                    (a <= FSC_KEY_BASE + 16'(FSC_KEY_BYTES - 1));
    endfunction : isKeyAddr

    fsc_key_cmp u_key (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .k       (keyLink.keymod)
    );

    // ****************************************************************
    // Key unit hookup
    // ****************************************************************
    logic keyEnabled;
    logic keyAccess;
    logic keyWrite;
    logic cfgWrite;
    logic srcTrusted;
    logic accessOk;
    logic rawWrite;
    logic rawRead;
    logic divTick;

    assign keyEnabled = st.option[FSC_OPT_BACKDOOR_KEY_ENABLE_BIT];
    assign keyAccess  = st.cfgReg[FSC_CFG_KEY_ACCESS_ENABLE_BIT];
    assign srcTrusted = memSrcSecure && !memSrcDebug;
    assign rawWrite   = memReq && memWr;
    assign rawRead    = memReq && !memWr;
    assign cfgWrite   = regWr && (regAddr == FSC_OFS_CONFIG);

    // Key bytes only from secure code with the mechanism enabled
    assign keyWrite = rawWrite && keyAccess && keyEnabled &&
                      isKeyAddr(memAddr) && srcTrusted;

    assign keyLink.wrEn    = keyWrite;
    assign keyLink.idx     = memAddr[2:0];
    assign keyLink.data    = memWdata;
    assign keyLink.nvKey   = nvKey;
    assign keyLink.restart = cfgWrite && !keyAccess &&
                             regWdata[FSC_CFG_KEY_ACCESS_ENABLE_BIT];
    assign keyLink.check   = cfgWrite && keyAccess &&
                             !regWdata[FSC_CFG_KEY_ACCESS_ENABLE_BIT];

    // Secure resources open to secure code, or to all when unsecured
    assign accessOk = !st.secure || !memTargetSecure ||
                      srcTrusted;

    // Divider input: bus clock, or every eighth bus clock
    assign divTick = !st.divider[FSC_DIV_PRESCALE_BIT] ||
                     (st.preCnt == FSC_PRESCALE_LAST);

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        next_st = st;
        next_st.firstCycle = 1'b0;
        next_st.regRdata   = 8'h00;
        next_st.flashPulse = 1'b0;

        // Register writes
        if (regWr) begin
            case (regAddr)
                FSC_OFS_DIVIDER: begin
                    if (!st.divider[FSC_DIV_LOADED_BIT]) begin
                        next_st.divider = (regWdata & FSC_DIV_WR_MASK) |
                            8'(1 << FSC_DIV_LOADED_BIT);
                    end
                end
                FSC_OFS_CONFIG: begin
                    next_st.cfgReg = regWdata & FSC_CFG_WR_MASK;
                end
                FSC_OFS_PROTECT: begin
                    if (regFromDebug) begin
                        next_st.protect = regWdata;
                    end
                end
                default: begin
                    // Option and status ignore writes
                    next_st.option = st.option;
                end
            endcase
        end

        // Register reads, data one cycle later
        if (regRd) begin
            case (regAddr)
                FSC_OFS_DIVIDER: next_st.regRdata = st.divider;
                FSC_OFS_OPTION:  next_st.regRdata =
                    st.option & FSC_OPT_RD_MASK;
                FSC_OFS_CONFIG:  next_st.regRdata = st.cfgReg;
                FSC_OFS_PROTECT: next_st.regRdata = st.protect;
                FSC_OFS_STATUS: begin
                    next_st.regRdata = {4'h0, st.bgEntryOk,
                                        st.dbgModuleEn,
                                        st.progEraseEn, st.secure};
                end
                default: next_st.regRdata = 8'h00;
            endcase
        end

        // Unlock by matching key or blank flash, until next reset
        if ((keyLink.match && keyEnabled) || blankCheckOk) begin
            next_st.option[1:0] = FSC_SEC_UNSECURED;
        end
        next_st.secure = isSecure(next_st.option);

        // Debug module and background entry
        next_st.dbgModuleEn = dbgEnableReq && !st.secure;
        next_st.bgEntryOk = !st.secure || st.bgPinLow;
        if (st.firstCycle) begin
            next_st.bgPinLow = !backgroundModePin;
        end

        // Vector block protection covers the key block
        next_st.keyProtected =
            !st.protect[FSC_PROT_DISABLE_BIT];
        // Loaded flag shows one cycle after the divider write
        next_st.progEraseEn =
            next_st.divider[FSC_DIV_LOADED_BIT];

        // Memory gate
        next_st.memWrEn    = rawWrite && accessOk && !keyWrite &&
                             !(memTargetFlash && keyAccess &&
                               isKeyAddr(memAddr));
        next_st.memWrData  = memWdata;
        next_st.memRdata   = (rawRead && accessOk) ?
                             arrayRdata : 8'h00;
        next_st.memBlocked = memReq && !accessOk;
        next_st.cmdWrite   = rawWrite && accessOk && memTargetFlash &&
                             st.divider[FSC_DIV_LOADED_BIT] &&
                             !(keyAccess && isKeyAddr(memAddr));

        // Flash clock: pulse once per (divisor+1) divider inputs
        if (st.divider[FSC_DIV_LOADED_BIT]) begin
            next_st.preCnt = st.preCnt + 3'h1;
            if (divTick) begin
                if (st.divCnt == st.divider[5:0]) begin
                    next_st.divCnt = 6'h00;
                    next_st.flashPulse = 1'b1;
                end else begin
                    next_st.divCnt = st.divCnt + 6'h01;
                end
            end
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            st            <= '0;
            st.divider    <= FSC_DIV_RESET;
            st.cfgReg     <= FSC_CFG_RESET;
            st.option     <= optNvByte;
            st.protect    <= protNvByte;
            st.secure     <= isSecure(optNvByte);
            st.firstCycle <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign regRdata     = st.regRdata;
    assign memWrEn      = st.memWrEn;
    assign memWrData    = st.memWrData;
    assign memRdata     = st.memRdata;
    assign memBlocked   = st.memBlocked;
    assign cmdWrite     = st.cmdWrite;
    assign secure       = st.secure;
    assign dbgModuleEn  = st.dbgModuleEn;
    assign bgEntryOk    = st.bgEntryOk;
    assign keyProtected = st.keyProtected;
    assign progEraseEn  = st.progEraseEn;
    assign flashPulse   = st.flashPulse;

endmodule : fsc_security

// *** verif/fsc_array_model.sv ***
// Behavioural flash and RAM array answering the gate's reads
module fsc_array_model (
    input  wire logic [15:0] memAddr,
    output logic      [7:0]  arrayRdata
);
    timeunit 1ns;
    timeprecision 100ps;
    // Pattern from the low address byte, so locations 256 apart read alike
    assign arrayRdata = memAddr[7:0] ^ 8'hA5;
endmodule : fsc_array_model

// *** verif/fsc_security_checker.sv ***
// Port-level assertions for the security gate and divider
module fsc_security_checker
    import fsc_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       resetn,
    input  wire logic [3:0] regAddr,
    input  wire logic       regWr,
    input  wire logic       regRd,
    input  wire logic [7:0] regRdata,
    input  wire logic       blankCheckOk,
    input  wire logic       memReq,
    input  wire logic       memWr,
    input  wire logic       memSrcSecure,
    input  wire logic       memSrcDebug,
    input  wire logic       memTargetSecure,
    input  wire logic [7:0] memRdata,
    input  wire logic       memWrEn,
    input  wire logic       memBlocked,
    input  wire logic       cmdWrite,
    input  wire logic       secure,
    input  wire logic       dbgModuleEn,
    input  wire logic       progEraseEn,
    input  wire logic       flashPulse
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    sequence untrustedReq;
        memReq && secure && memTargetSecure && !(memSrcSecure && !memSrcDebug);
    endsequence
    sequence blockedAns;
        memBlocked && !memWrEn && memRdata == 8'h00;
    endsequence
    access_blocked_a: assert property (untrustedReq |=> blockedAns)
        else $error("untrusted access was not blocked");
    trusted_pass_a: assert property (memReq && memTargetSecure
        && memSrcSecure && !memSrcDebug |=> !memBlocked)
        else $error("trusted access was blocked");
    debug_refused_a: assert property (secure |-> !dbgModuleEn)
        else $error("debug module enabled while secure");
    blank_unlock_a: assert property (blankCheckOk |=> !secure)
        else $error("blank check did not unsecure");
    unlock_sticky_a: assert property (!secure |=> !secure)
        else $error("security returned before reset");
    loaded_flag_a: assert property (regWr && regAddr == FSC_OFS_DIVIDER
        |=> progEraseEn) else $error("divider write did not load");
    loaded_stays_a: assert property (progEraseEn |=> progEraseEn)
        else $error("loaded flag dropped");
    pulse_gated_a: assert property (flashPulse |-> progEraseEn)
        else $error("flash pulse before divider loaded");
    cmd_gated_a: assert property (memReq && memWr && !progEraseEn
        |=> !cmdWrite) else $error("command step before divider loaded");
    read_window_a: assert property (!regRd |=> regRdata == 8'h00)
        else $error("read data outside its cycle");
endmodule : fsc_security_checker
bind fsc_security fsc_security_checker u_fsc_security_checker (.*);

// *** verif/tb_top.sv ***
// Self-checking bench for the flash security gate and divider
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import fsc_pkg::*;
    logic ref_clk = 0, resetn = 0, regWr = 0, regRd = 0, regFromDebug = 0;
    logic backgroundModePin = 0, dbgEnableReq = 0, blankCheckOk = 0;
    logic memReq = 0, memWr = 0, memSrcSecure = 0, memSrcDebug = 0;
    logic memTargetSecure = 1, memTargetFlash = 1;
    logic [3:0]  regAddr = 4'h0;
    logic [7:0]  regWdata = 8'h00, optNvByte = 8'h03, protNvByte = 8'hFF;
    logic [7:0]  memWdata = 8'h00, arrayRdata, regRdata, memWrData, memRdata;
    logic [7:0]  n;
    logic [15:0] memAddr = 16'h0000;
    logic [63:0] nvKey = 64'h0123456789ABCDEF;
    logic memWrEn, memBlocked, cmdWrite, secure, dbgModuleEn, bgEntryOk;
    logic keyProtected, progEraseEn, flashPulse;
    int   miscompares = 0, compares = 0;
    fsc_security    u_fsc_security (.*);
    fsc_array_model u_fsc_array_model (.*);
    initial forever #2.5 ref_clk = ~ref_clk;
    task chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task chkb(input logic got, input logic exp);
        chk({7'h00, got}, {7'h00, exp});
    endtask : chkb
    task cyc(input int k);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask : cyc
    task rst(input logic [7:0] nv);
        @(posedge ref_clk);
        resetn <= 1'b0;
        optNvByte <= nv;
        repeat (6) @(posedge ref_clk);
        resetn <= 1'b1;
        cyc(2);
    endtask : rst
    task wr(input logic [3:0] a, input logic [7:0] d, input logic dbg);
        @(posedge ref_clk);
        regAddr <= a;
        regWdata <= d;
        regFromDebug <= dbg;
        regWr <= 1'b1;
        @(posedge ref_clk);
        regWr <= 1'b0;
    endtask : wr
    task rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge ref_clk);
        regRd <= 1'b0;
        #1;
        chk(regRdata, exp);
    endtask : rd
    task mem(input logic w, input logic [15:0] a, input logic [7:0] d,
             input logic src, input logic dbg);
        @(posedge ref_clk);
        memReq <= 1'b1;
        memWr <= w;
        memAddr <= a;
        memWdata <= d;
        memSrcSecure <= src;
        memSrcDebug <= dbg;
        @(posedge ref_clk);
        memReq <= 1'b0;
        #1;
    endtask : mem
    task gap(output logic [7:0] cnt);
        cnt = 8'h00;
        repeat (300) begin
            cyc(1);
            if (flashPulse) break;
        end
        repeat (300) begin
            cyc(1);
            cnt++;
            if (flashPulse) break;
        end
    endtask : gap
    task t_codes;
        for (int s = 0; s < 4; s++) begin
            rst({6'h20, s[1:0]});
            chkb(secure, s != 2);
            rd(FSC_OFS_OPTION, {6'h20, s[1:0]});
            wr(FSC_OFS_OPTION, 8'h00, 1'b0);
            rd(FSC_OFS_OPTION, {6'h20, s[1:0]});
        end
        $display("security codes done");
    endtask : t_codes
    task t_gate;
        backgroundModePin <= 1'b1;
        rst(8'h83);
        chkb(bgEntryOk, 1'b0);
        backgroundModePin <= 1'b0;
        rst(8'h83);
        chkb(bgEntryOk, 1'b1);
        mem(1'b0, 16'hE012, 8'h00, 1'b0, 1'b0);
        chk(memRdata, 8'h00);
        chkb(memBlocked, 1'b1);
        mem(1'b1, 16'hE012, 8'h5A, 1'b1, 1'b1);
        chkb(memWrEn, 1'b0);
        mem(1'b0, 16'hE034, 8'h00, 1'b1, 1'b0);
        chk(memRdata, 8'h91);
        dbgEnableReq <= 1'b1;
        cyc(2);
        chkb(dbgModuleEn, 1'b0);
        blankCheckOk <= 1'b1;
        @(posedge ref_clk);
        blankCheckOk <= 1'b0;
        #1;
        chkb(secure, 1'b0);
        cyc(2);
        chkb(dbgModuleEn, 1'b1);
        mem(1'b0, 16'hE034, 8'h00, 1'b0, 1'b0);
        chkb(memBlocked, 1'b0);
        rd(FSC_OFS_STATUS, 8'h0C);
        dbgEnableReq <= 1'b0;
        $display("access gate done");
    endtask : t_gate
    task t_div;
        rst(8'h02);
        rd(FSC_OFS_DIVIDER, 8'h00);
        mem(1'b1, 16'hE000, 8'h11, 1'b1, 1'b0);
        chkb(cmdWrite, 1'b0);
        wr(FSC_OFS_DIVIDER, 8'h4E, 1'b0);
        rd(FSC_OFS_DIVIDER, 8'hCE);
        wr(FSC_OFS_DIVIDER, 8'h01, 1'b0);
        rd(FSC_OFS_DIVIDER, 8'hCE);
        chkb(progEraseEn, 1'b1);
        mem(1'b1, 16'hE000, 8'h11, 1'b1, 1'b0);
        chkb(cmdWrite, 1'b1);
        gap(n);
        chk(n, 8'h78);
        rst(8'h02);
        wr(FSC_OFS_DIVIDER, 8'h03, 1'b0);
        gap(n);
        chk(n, 8'h04);
        $display("clock divider done");
    endtask : t_div
    task t_key(input logic [7:0] nv, input logic bad, input logic dbg,
               input logic exp);
        rst(nv);
        wr(FSC_OFS_CONFIG, 8'h20, 1'b0);
        for (int i = 0; i < FSC_KEY_BYTES; i++) begin
            mem(1'b1, FSC_KEY_BASE + 16'(i),
                nvKey[8*i +: 8] ^ {7'h00, bad && i == 7}, !dbg, dbg);
            chkb(memWrEn, 1'b0);
        end
        wr(FSC_OFS_CONFIG, 8'h00, 1'b0);
        cyc(3);
        chkb(secure, exp);
        $display("key entry done");
    endtask : t_key
    task t_prot;
        rst(8'h02);
        rd(FSC_OFS_PROTECT, 8'hFF);
        chkb(keyProtected, 1'b0);
        wr(FSC_OFS_PROTECT, 8'h00, 1'b0);
        rd(FSC_OFS_PROTECT, 8'hFF);
        wr(FSC_OFS_PROTECT, 8'h00, 1'b1);
        rd(FSC_OFS_PROTECT, 8'h00);
        chkb(keyProtected, 1'b1);
        rd(4'hF, 8'h00);
        $display("protection done");
    endtask : t_prot
    task close_out;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : close_out
    initial begin
        rst(8'h03);
        t_codes;
        t_gate;
        t_div;
        t_key(8'h83, 1'b0, 1'b0, 1'b0);
        t_key(8'h83, 1'b1, 1'b0, 1'b1);
        t_key(8'h03, 1'b0, 1'b0, 1'b1);
        t_key(8'h83, 1'b0, 1'b1, 1'b1);
        t_prot;
        close_out;
    end
    initial begin
        #100000;
        miscompares++;
        close_out;
    end
endmodule : tb_top
